// ### verilog/chan_pkg.sv
package chan_pkg;

   // Bit timing
   localparam int CLK_NS = 25;
   localparam int BIT_TIME_NS = 1600;
   localparam int BIT_CYC = (BIT_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [5:0] BIT_LAST = 6'(BIT_CYC - 1);
   localparam logic [5:0] BIT_MID = 6'(BIT_CYC / 2);

   // State counter values
   localparam logic [3:0] ST_QUIET0 = 4'h0;
   localparam logic [3:0] ST_QUIET1 = 4'h1;
   localparam logic [3:0] ST_ARM = 4'h2;
   localparam logic [3:0] ST_BIT_FIRST = 4'h3;
   localparam logic [3:0] ST_BIT_LAST = 4'h9;
   localparam logic [3:0] ST_PAR_A = 4'ha;
   localparam logic [3:0] ST_PAR_B = 4'hb;
   localparam logic [3:0] ST_END = 4'hc;
   localparam logic [3:0] ST_ACK_CLK = 4'hd;
   localparam logic [3:0] ST_ACK_DATA = 4'he;
   localparam logic [3:0] ST_ACK_END = 4'hf;

   // Characters, bit 1 sent first
   localparam logic [6:0] ESC_CHAR = 7'h10;
   localparam logic [6:0] LOAD_POLL_CHAR = 7'h30;
   localparam logic [6:0] SVC_POLL_BIT = 7'h20;

   // Register port
   localparam logic [1:0] ADDR_SELECT = 2'h0;
   localparam logic [1:0] ADDR_CTRL = 2'h1;
   localparam logic [1:0] ADDR_POLL = 2'h2;
   localparam int CTRL_CLR_LOAD = 0;
   localparam int CTRL_CLR_SVC = 1;
   localparam int CTRL_OP_DONE = 2;

   typedef enum logic [1:0] {
      MODE_ESC = 2'b01,
      MODE_SEL = 2'b10
   } mode_t;

   typedef struct packed {
      logic guard;
      logic load_toggle;
      logic retry;
      logic busy;
      logic svc_flop;
      logic svc_req;
      logic ld_req;
      logic select;
      logic polling;
      logic data;
      logic ld_polled;
      logic sv_polled;
      logic op_pend;
   } flags_t;

   localparam flags_t FLAGS_RESET = 13'h1000;

endpackage

// ### verilog/channel_line_escape_poll_select.sv
module channel_line_escape_poll_select (
   input wire logic clock,
   input wire logic rstn,
   input wire logic line_in,
   output logic line_out,
   output logic line_oe,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic load_request_flag,
   output logic service_request_flag,
   output logic channel_busy
);

   logic rst_meta_q, rst_sync_q;
   logic line_meta_q, line_sync_q, line_prev_q;
   logic line_edge;
   chan_pkg::mode_t mode_q, mode_d;
   logic [3:0] st_q, st_d;
   logic [5:0] bit_q, bit_d;
   chan_pkg::flags_t f_q, f_d;
   logic line_lvl_q, line_lvl_d;
   logic line_drive_enable_q, line_drive_enable_d;
   logic [3:0] poll_cnt_q, poll_cnt_d;
   logic [6:0] poll_char_q, poll_char_d;
   logic [6:0] channel_shift_reg_q, channel_shift_reg_d;
   logic parity_gen_first_q, parity_gen_first_d;
   logic parity_gen_second_q, parity_gen_second_d;
   logic seen_q, seen_d;
   logic [7:0] rdata_q, rdata_d;
   logic end_bit, tx_sel, tx_ld, cur_bit, got_edge;

   function automatic logic in_span(input logic [3:0] s, input logic [3:0] lo,
                                    input logic [3:0] hi);
      in_span = (s >= lo) && (s <= hi);
   endfunction

   // Reset release, two stages
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // Line is asynchronous to the clock
   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         line_meta_q <= 1'b0;
         line_sync_q <= 1'b0;
         line_prev_q <= 1'b0;
      end else begin
         line_meta_q <= line_in;
         line_sync_q <= line_meta_q;
         line_prev_q <= line_sync_q;
      end
   end

   // Our own drive is seen too, but only while the quiet check is not running
   assign line_edge = line_sync_q ^ line_prev_q;
   assign end_bit = (bit_q == chan_pkg::BIT_LAST);
   assign got_edge = seen_q | line_edge;
   assign tx_sel = (mode_q == chan_pkg::MODE_SEL) && !f_q.polling;
   assign tx_ld = (mode_q == chan_pkg::MODE_SEL) && f_q.polling &&
                  f_q.load_toggle;

   always_comb begin
      if (st_q <= chan_pkg::ST_BIT_LAST) begin
         cur_bit = tx_sel ? channel_shift_reg_q[0] : poll_char_q[0];
      end else begin
         cur_bit = tx_ld | parity_gen_first_q;
      end
   end

   always_comb begin
      mode_d = mode_q;
      st_d = st_q;
      f_d = f_q;
      line_lvl_d = line_lvl_q;
      line_drive_enable_d = line_drive_enable_q;
      poll_cnt_d = poll_cnt_q;
      poll_char_d = poll_char_q;
      channel_shift_reg_d = channel_shift_reg_q;
      parity_gen_first_d = parity_gen_first_q;
      parity_gen_second_d = parity_gen_second_q;
      bit_d = end_bit ? 6'h00 : bit_q + 6'h01;
      seen_d = end_bit ? 1'b0 : got_edge;
      rdata_d = 8'h00;

      // Software side; hardware sets further down win over these clears
      if (reg_wr && reg_addr == chan_pkg::ADDR_SELECT && !f_q.busy) begin
         channel_shift_reg_d = reg_wdata[6:0];
         f_d.busy = 1'b1;
         f_d.svc_flop = 1'b0;
      end
      if (reg_wr && reg_addr == chan_pkg::ADDR_CTRL) begin
         if (reg_wdata[chan_pkg::CTRL_CLR_LOAD]) f_d.ld_req = 1'b0;
         if (reg_wdata[chan_pkg::CTRL_CLR_SVC]) f_d.svc_req = 1'b0;
         if (reg_wdata[chan_pkg::CTRL_OP_DONE]) f_d.op_pend = 1'b1;
      end
      if (reg_rd) begin
         case (reg_addr)
            chan_pkg::ADDR_SELECT: rdata_d = {1'b0, channel_shift_reg_q};
            chan_pkg::ADDR_CTRL: rdata_d = {f_q.guard, f_q.load_toggle,
               f_q.retry, f_q.busy, f_q.svc_flop, f_q.svc_req, f_q.ld_req,
               f_q.select};
            chan_pkg::ADDR_POLL: rdata_d = {mode_q, f_q.polling, 1'b0,
                                            poll_cnt_q};
            default: rdata_d = 8'h00;
         endcase
      end

      // Serial transmit, shared by escape, polls and selection
      if (line_drive_enable_q &&
          in_span(st_q, chan_pkg::ST_BIT_FIRST, chan_pkg::ST_PAR_B)) begin
         if (bit_q == 6'h00) begin
            line_lvl_d = ~line_lvl_q;
         end else if (bit_q == chan_pkg::BIT_MID && cur_bit) begin
            line_lvl_d = ~line_lvl_q;
         end
         if (end_bit && st_q <= chan_pkg::ST_BIT_LAST) begin
            poll_char_d = {1'b0, poll_char_q[6:1]};
            if (tx_sel) begin
               channel_shift_reg_d = {channel_shift_reg_q[0],
                                      channel_shift_reg_q[6:1]};
            end
            if (st_q[0]) parity_gen_first_d = parity_gen_first_q ^ cur_bit;
            else parity_gen_second_d = parity_gen_second_q ^ cur_bit;
         end
         if (end_bit && st_q == chan_pkg::ST_PAR_A) begin
            parity_gen_first_d = parity_gen_second_q;
         end
      end
      if (end_bit && in_span(st_q, chan_pkg::ST_BIT_FIRST,
                              chan_pkg::ST_PAR_B)) begin
         st_d = st_q + 4'h1;
      end

      case (mode_q)
         chan_pkg::MODE_ESC: begin
            case (st_q)
               chan_pkg::ST_QUIET0, chan_pkg::ST_QUIET1: begin
                  line_drive_enable_d = 1'b0;
                  if (st_q == chan_pkg::ST_QUIET0) f_d.select = 1'b0;
                  if (line_edge) begin
                     st_d = chan_pkg::ST_QUIET0;
                     bit_d = 6'h00;
                     seen_d = 1'b0;
                  end else if (end_bit) begin
                     st_d = st_q + 4'h1;
                  end
               end
               chan_pkg::ST_ARM: begin
                  line_drive_enable_d = 1'b1;
                  poll_char_d = chan_pkg::ESC_CHAR;
                  parity_gen_first_d = 1'b0;
                  parity_gen_second_d = 1'b0;
                  if (end_bit) st_d = chan_pkg::ST_BIT_FIRST;
               end
               chan_pkg::ST_END: begin
                  line_drive_enable_d = 1'b0;
                  if (!line_drive_enable_q) f_d.select = 1'b1;
                  if (!f_q.load_toggle && f_q.ld_polled && f_q.sv_polled) begin
                     f_d.guard = 1'b0;
                  end
                  if (end_bit) st_d = chan_pkg::ST_ACK_CLK;
               end
               chan_pkg::ST_ACK_CLK: begin
                  if (end_bit) begin
                     f_d.polling = f_q.guard | !f_q.busy;
                     if (f_q.guard | !f_q.busy) begin
                        f_d.load_toggle = ~f_q.load_toggle;
                     end
                     st_d = chan_pkg::ST_ACK_DATA;
                  end
               end
               chan_pkg::ST_ACK_DATA: begin
                  if (end_bit) st_d = chan_pkg::ST_ACK_END;
               end
               chan_pkg::ST_ACK_END: begin
                  if (f_q.op_pend) begin
                     f_d.guard = 1'b1;
                     f_d.ld_polled = 1'b0;
                     f_d.sv_polled = 1'b0;
                     f_d.op_pend = 1'b0;
                  end
                  if (end_bit) begin
                     mode_d = chan_pkg::MODE_SEL;
                     st_d = chan_pkg::ST_ARM;
                  end
               end
               default: ;
            endcase
         end
         chan_pkg::MODE_SEL: begin
            case (st_q)
               chan_pkg::ST_ARM: begin
                  line_drive_enable_d = 1'b1;
                  parity_gen_first_d = 1'b0;
                  parity_gen_second_d = 1'b0;
                  if (end_bit) begin
                     st_d = chan_pkg::ST_BIT_FIRST;
                     if (f_q.polling && f_q.load_toggle) begin
                        poll_char_d = chan_pkg::LOAD_POLL_CHAR;
                        f_d.ld_polled = 1'b1;
                     end else if (f_q.polling) begin
                        if (!f_q.svc_flop) begin
                           poll_cnt_d = poll_cnt_q + 4'h1;
                        end
                        poll_char_d = chan_pkg::SVC_POLL_BIT |
                                      {3'h0, poll_cnt_d};
                        f_d.sv_polled = 1'b1;
                     end
                  end
               end
               chan_pkg::ST_END: begin
                  line_drive_enable_d = 1'b0;
                  if (end_bit) st_d = chan_pkg::ST_ACK_CLK;
               end
               chan_pkg::ST_ACK_CLK: begin
                  f_d.data = 1'b0;
                  if (end_bit) begin
                     if (got_edge) begin
                        st_d = chan_pkg::ST_ACK_DATA;
                     end else begin
                        f_d.retry = !f_q.polling;
                        mode_d = chan_pkg::MODE_ESC;
                        st_d = chan_pkg::ST_QUIET0;
                     end
                  end
               end
               chan_pkg::ST_ACK_DATA: begin
                  if (line_edge) f_d.data = 1'b1;
                  if (end_bit) st_d = chan_pkg::ST_ACK_END;
               end
               chan_pkg::ST_ACK_END: begin
                  if (end_bit) begin
                     mode_d = chan_pkg::MODE_ESC;
                     st_d = chan_pkg::ST_QUIET0;
                     if (got_edge && f_q.data) begin
                        f_d.retry = 1'b0;
                        if (f_q.polling && f_q.load_toggle) begin
                           f_d.ld_req = 1'b1;
                        end else if (f_q.polling) begin
                           f_d.svc_req = 1'b1;
                           f_d.svc_flop = 1'b1;
                        end else begin
                           // Transfer phase not modelled: treat as done
                           f_d.busy = 1'b0;
                           f_d.op_pend = 1'b1;
                        end
                     end else begin
                        f_d.retry = !f_q.polling;
                     end
                  end
               end
               default: ;
            endcase
         end
         default: begin
            mode_d = chan_pkg::MODE_ESC;
            st_d = chan_pkg::ST_QUIET0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         mode_q <= chan_pkg::MODE_ESC;
         st_q <= chan_pkg::ST_QUIET0;
         bit_q <= 6'h00;
         f_q <= chan_pkg::FLAGS_RESET;
         line_lvl_q <= 1'b0;
         line_drive_enable_q <= 1'b0;
         poll_cnt_q <= 4'h0;
         poll_char_q <= 7'h00;
         channel_shift_reg_q <= 7'h00;
         parity_gen_first_q <= 1'b0;
         parity_gen_second_q <= 1'b0;
         seen_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         mode_q <= mode_d;
         st_q <= st_d;
         bit_q <= bit_d;
         f_q <= f_d;
         line_lvl_q <= line_lvl_d;
         line_drive_enable_q <= line_drive_enable_d;
         poll_cnt_q <= poll_cnt_d;
         poll_char_q <= poll_char_d;
         channel_shift_reg_q <= channel_shift_reg_d;
         parity_gen_first_q <= parity_gen_first_d;
         parity_gen_second_q <= parity_gen_second_d;
         seen_q <= seen_d;
         rdata_q <= rdata_d;
      end
   end

   assign line_out = line_lvl_q;
   assign line_oe = line_drive_enable_q;
   assign reg_rdata = rdata_q;
   assign load_request_flag = f_q.ld_req;
   assign service_request_flag = f_q.svc_req;
   assign channel_busy = f_q.busy;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_sync_q);

   sequence s_quiet_edge;
      mode_q == chan_pkg::MODE_ESC && st_q <= chan_pkg::ST_QUIET1 && line_edge;
   endsequence
   sequence s_ack_ok;
      mode_q == chan_pkg::MODE_SEL && st_q == chan_pkg::ST_ACK_END &&
         end_bit && got_edge && f_q.data;
   endsequence
   sequence s_ack_miss_poll;
      mode_q == chan_pkg::MODE_SEL && st_q == chan_pkg::ST_ACK_CLK &&
         end_bit && !got_edge && f_q.polling;
   endsequence

   property p_quiet;
      s_quiet_edge |=> st_q == chan_pkg::ST_QUIET0 && bit_q == 6'h00;
   endproperty
   a_quiet: assert property (p_quiet) else $error("quiet restart");

   property p_sel_clear;
      mode_q == chan_pkg::MODE_ESC && st_q == chan_pkg::ST_QUIET0
         |=> !f_q.select;
   endproperty
   a_sel_clear: assert property (p_sel_clear) else $error("select kept");

   property p_esc_bit5;
      mode_q == chan_pkg::MODE_ESC && line_drive_enable_q &&
         bit_q == chan_pkg::BIT_MID &&
         in_span(st_q, chan_pkg::ST_BIT_FIRST, chan_pkg::ST_BIT_LAST)
         |=> (line_lvl_q != $past(line_lvl_q)) == ($past(st_q) == 4'h7);
   endproperty
   a_esc_bit5: assert property (p_esc_bit5) else $error("escape char");

   property p_drop;
      st_q == chan_pkg::ST_END && bit_q == 6'h01 |-> !line_drive_enable_q;
   endproperty
   a_drop: assert property (p_drop) else $error("drive kept");

   property p_toggle;
      $changed(f_q.load_toggle) |-> $past(st_q) == chan_pkg::ST_ACK_CLK &&
         $past(mode_q) == chan_pkg::MODE_ESC;
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle off state");

   property p_guard_set;
      $rose(f_q.guard) |-> $past(st_q) == chan_pkg::ST_ACK_END;
   endproperty
   a_guard_set: assert property (p_guard_set) else $error("guard set");

   property p_cnt_hold;
      $changed(poll_cnt_q) |-> !$past(f_q.svc_flop);
   endproperty
   a_cnt_hold: assert property (p_cnt_hold) else $error("counter stepped");

   property p_ld_parity;
      tx_ld && line_drive_enable_q && bit_q == chan_pkg::BIT_MID &&
         (st_q == chan_pkg::ST_PAR_A || st_q == chan_pkg::ST_PAR_B)
         |=> line_lvl_q != $past(line_lvl_q);
   endproperty
   a_ld_parity: assert property (p_ld_parity) else $error("load parity");

   property p_ack_ok;
      s_ack_ok |=> !f_q.retry ##1 mode_q == chan_pkg::MODE_ESC;
   endproperty
   a_ack_ok: assert property (p_ack_ok) else $error("retry not reset");

   property p_poll_miss;
      s_ack_miss_poll |=> !f_q.retry && st_q == chan_pkg::ST_QUIET0;
   endproperty
   a_poll_miss: assert property (p_poll_miss) else $error("poll retried");

   property p_sel_noflag;
      tx_sel |=> !$rose(f_q.ld_req) && !$rose(f_q.svc_req);
   endproperty
   a_sel_noflag: assert property (p_sel_noflag) else $error("flag on select");

endmodule // channel_line_escape_poll_select

// ### bench/line_unit_model.sv
module line_unit_model (
   input wire logic clock,
   input wire logic rstn,
   input wire logic line_out,
   input wire logic line_oe,
   input wire logic ack_en,
   output logic wire_lvl,
   output logic [8:0] chr,
   output logic chr_acked,
   output logic chr_stb
);
   timeunit 1ns;
   timeprecision 1ns;
   logic oe_q;
   logic smp;
   logic tgl;
   int c;
   // Unit acks twice; the second one-bit spills into the next quiet check
   assign tgl = chr_acked && (c == 704 || c == 800 || c == 832 ||
                              c == 864 || c == 896);
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         oe_q <= 1'b0;
         c <= 1000;
         wire_lvl <= 1'b0;
         chr <= 9'h000;
         chr_acked <= 1'b0;
         chr_stb <= 1'b0;
         smp <= 1'b0;
      end else begin
         oe_q <= line_oe;
         chr_stb <= oe_q && !line_oe;
         c <= (line_oe && !oe_q) ? 0 : c + 1;
         // Line keeps its level once released: no phantom edge at turnaround
         wire_lvl <= line_oe ? line_out : wire_lvl ^ tgl;
         if (c >= 64 && c < 640 && c % 64 == 16) begin
            smp <= line_out;
         end
         if (c >= 64 && c < 640 && c % 64 == 48) begin
            chr[c / 64 - 1] <= smp ^ line_out;
         end
         // Escape characters are never acknowledged by a unit
         if (oe_q && !line_oe) begin
            chr_acked <= ack_en && chr[6:0] != 7'h10;
         end
      end
   end
endmodule // line_unit_model

// ### bench/test_channel_line_escape_poll_select.sv
module test_channel_line_escape_poll_select;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rstn, line_in, line_out, line_oe, reg_wr, reg_rd, rd_q;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic load_request_flag, service_request_flag, channel_busy, ack_en;
   logic [8:0] chr;
   logic chr_acked, chr_stb;
   logic [7:0] rq[$];
   logic [6:0] sel;
   logic [3:0] cnt;
   logic nesc, tog, g, bsy, opp, pol, lk, lds, svs, ldf, svf;
   logic [31:0] rnd;
   int miscompares, compares, nchr;

   channel_line_escape_poll_select dut_u (
      .clock(clock), .rstn(rstn), .line_in(line_in), .line_out(line_out),
      .line_oe(line_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .load_request_flag(load_request_flag),
      .service_request_flag(service_request_flag),
      .channel_busy(channel_busy));
   line_unit_model unit_u (
      .clock(clock), .rstn(rstn), .line_out(line_out), .line_oe(line_oe),
      .ack_en(ack_en), .wire_lvl(line_in), .chr(chr),
      .chr_acked(chr_acked), .chr_stb(chr_stb));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Sent order: bits 1..7, then odd-bit parity, then even-bit parity
   function automatic logic [8:0] enc(input logic [6:0] v);
      return {v[1] ^ v[3] ^ v[5], v[0] ^ v[2] ^ v[4] ^ v[6], v};
   endfunction

   task automatic chk(input logic [8:0] got, input logic [8:0] exp,
                      input string m);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask

   task automatic conclude;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      // Let an edge pass so a following strobe is not driven twice at once
      @(posedge clock);
   endtask

   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      rq.push_back(exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wait_chars(input int n);
      int t;
      int s;
      t = 0;
      s = nchr + n;
      while (nchr < s) begin
         @(posedge clock);
         t++;
         if (t > 1300 * n) begin
            miscompares++;
            $display("unexpected at %0t: line stalled", $time);
            conclude();
         end
      end
   endtask

   always @(posedge clock) begin
      rd_q <= reg_rd;
      if (rd_q) begin
         chk({1'b0, reg_rdata}, {1'b0, rq.pop_front()}, "read");
      end
   end

   // Predicts each character the unit decodes from the controller
   always @(posedge clock) begin
      if (chr_stb) begin
         nchr++;
         chk({6'h00, load_request_flag, service_request_flag, channel_busy},
             {6'h00, ldf, svf, bsy}, "flags");
         if (nesc) begin
            chk(chr, enc(7'h10), "escape");
            if (g && !tog && lds && svs) g = 1'b0;
            pol = g | !bsy;
            if (pol) tog = !tog;
            if (opp) begin
               g = 1'b1;
               opp = 1'b0;
               lds = 1'b0;
               svs = 1'b0;
            end
         end else if (pol && tog) begin
            chk(chr, enc(7'h30), "load poll");
            lds = 1'b1;
            ldf = ldf | chr_acked;
         end else if (pol) begin
            if (!lk) cnt = cnt + 4'h1;
            chk(chr, enc({3'h2, cnt}), "service poll");
            svs = 1'b1;
            svf = svf | chr_acked;
            lk = lk | chr_acked;
         end else begin
            chk(chr, enc(sel), "select");
            bsy = bsy & !chr_acked;
            opp = chr_acked;
         end
         nesc = !nesc;
      end
   end

   initial begin
      rstn = 1'b0;
      reg_addr = 2'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      rd_q = 1'b0;
      ack_en = 1'b0;
      {nesc, g} = 2'b11;
      {tog, bsy, opp, pol, lk, lds, svs, ldf, svf} = 9'h000;
      cnt = 4'h0;
      sel = 7'h00;
      rnd = 32'h00cab35d;
      miscompares = 0;
      compares = 0;
      nchr = 0;
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      repeat (3) @(posedge clock);
      rd(2'h1, 8'h80);
      rd(2'h3, 8'h00);
      wait_chars(8);
      $display("idle polling test done");
      ack_en <= 1'b1;
      wait_chars(4);
      ack_en <= 1'b0;
      wait_chars(4);
      $display("poll answer test done");
      wr(2'h1, 8'h03);
      ldf = 1'b0;
      svf = 1'b0;
      rnd = lfsr(rnd);
      sel = {1'b1, rnd[5:0]};
      wr(2'h0, {1'b0, sel});
      bsy = 1'b1;
      lk = 1'b0;
      // Ignored while busy: the first character must go out
      wr(2'h0, {1'b0, ~sel});
      rd(2'h0, {1'b0, sel});
      wait_chars(4);
      ack_en <= 1'b1;
      wait_chars(2);
      ack_en <= 1'b0;
      wait_chars(6);
      $display("select and retry test done");
      conclude();
   end
endmodule // test_channel_line_escape_poll_select
